// >>> motor_driver_io_control.sv
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "motor_io_params.svh"
// Notes on behaviour
// - motor ramps up only while run request and run permit are both active
// - run request released: motor decelerates to rest over decel ramp
// - run permit released: motor stops at once, no ramp
// - direction input active commands forward, inactive commands reverse
// - two select inputs pick the active operation data entry
// - fault cleared only on inactive-to-active edge of clear input
// - thirty shaft pulses per output shaft revolution
// - fault-ok output active normally, inactive while alarm pending
// - torque-capped output active while torque is clamped by limit
// - torque limit defaults to 200 percent, software may change it
// - rotation sense output active while turning forward
// - inputs active low by default; far side drives accordingly
// - each input terminal has its own polarity inversion before decode
// - each output has polarity, ignored on the shaft pulse terminal
// - terminal functions reassignable from a fixed default map
// - speed and torque references from analog or pwm per setting
// - option inverts commanded direction to physical rotation
module motor_driver_io_control #(
  parameter int RAMP_W = 16,
  parameter int POS_W = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [5:0] digitalInputTerminals,
  output logic [3:0] digitalOutputTerminals,
  input wire logic [15:0] analogSpeedRef,
  input wire logic [15:0] pwmSpeedRef,
  input wire logic [15:0] analogTorqueRef,
  input wire logic [15:0] pwmTorqueRef,
  input wire logic [15:0] torqueDemand,
  input wire logic shaftTick,
  input wire logic alarmEvent,
  output logic motorEnable,
  output logic motorForward,
  output logic [RAMP_W-1:0] speedLevel,
  output logic [1:0] dataEntry,
  output logic [15:0] speedRef,
  output logic [15:0] torqueRef
);
  // refused at elaboration: ramp wider than half a bus word cannot be set
  if (RAMP_W < 2 || RAMP_W > 16 || POS_W < 5) begin : g_bad_param
    $error("motor_driver_io_control: bad parameter");
  end

  // select the polarity-inverted input bit carried by a function
  function automatic logic pickIn(input logic [5:0] act,
                                  input logic [17:0] map,
                                  input motor_io_pkg::in_func_t fn);
    logic res;
    res = 1'b0;
    for (int t = 0; t < 6; t++) begin
      if (map[t*3 +: 3] == fn) begin
        res = act[t];
      end
    end
    return res;
  endfunction

  // register state
  logic [2:0] ctrl_q;
  logic [5:0] inPol_q;
  logic [3:0] outPol_q;
  logic [17:0] inMap_q;
  logic [7:0] outMap_q;
  logic [15:0] tLim_q;
  logic [RAMP_W-1:0] accelStep_q;
  logic [RAMP_W-1:0] decelStep_q;

  logic [5:0] pinSync;
  pin_sync #(.WIDTH(6)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pinAsync(digitalInputTerminals),
    .pinSync(pinSync)
  );

  // low level is active unless inverted
  wire [5:0] inActive = ~pinSync ^ inPol_q;

  wire runReq = pickIn(inActive, inMap_q, motor_io_pkg::FN_RUN_REQ);
  wire runPermit = pickIn(inActive, inMap_q, motor_io_pkg::FN_RUN_PERMIT);
  wire dirIn = pickIn(inActive, inMap_q, motor_io_pkg::FN_DIRECTION);
  wire selLow = pickIn(inActive, inMap_q, motor_io_pkg::FN_SEL_LOW);
  wire selHigh = pickIn(inActive, inMap_q, motor_io_pkg::FN_SEL_HIGH);
  wire clrIn = pickIn(inActive, inMap_q, motor_io_pkg::FN_FAULT_CLEAR);

  // motion state machine
  motor_io_pkg::motion_t state_q, state_d;
  logic [RAMP_W-1:0] speed_q, speed_d;
  logic clrPrev_q;
  logic alarm_q;
  logic [POS_W-1:0] tickCnt_q;
  logic pulse_q;
  logic fwd_q;

  wire [RAMP_W-1:0] topSpeed = {RAMP_W{1'b1}};
  wire [RAMP_W:0] upSum = {1'b0, speed_q} + {1'b0, accelStep_q};
  wire upDone = upSum >= {1'b0, topSpeed};
  wire downDone = speed_q <= decelStep_q;
  wire runOk = runReq && runPermit && !alarm_q;

  // next state and speed
  always_comb begin
    state_d = state_q;
    speed_d = speed_q;
    unique case (state_q)
      motor_io_pkg::MS_IDLE: begin
        if (runOk) begin
          state_d = motor_io_pkg::MS_RAMP_UP;
        end
      end
      motor_io_pkg::MS_RAMP_UP, motor_io_pkg::MS_RUN: begin
        if (!runOk) begin
          state_d = motor_io_pkg::MS_RAMP_DOWN;
        end else if (upDone) begin
          state_d = motor_io_pkg::MS_RUN;
          speed_d = topSpeed;
        end else begin
          speed_d = upSum[RAMP_W-1:0];
        end
      end
      motor_io_pkg::MS_RAMP_DOWN: begin
        if (runOk) begin
          state_d = motor_io_pkg::MS_RAMP_UP;
        end else if (downDone) begin
          state_d = motor_io_pkg::MS_IDLE;
          speed_d = '0;
        end else begin
          speed_d = speed_q - decelStep_q;
        end
      end
    endcase
    // permit loss stops at once; alarm does too
    if (!runPermit || alarm_q) begin
      state_d = motor_io_pkg::MS_IDLE;
      speed_d = '0;
    end
  end

  // state registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= motor_io_pkg::MS_IDLE;
      speed_q <= '0;
    end else begin
      state_q <= state_d;
      speed_q <= speed_d;
    end
  end

  // clear on rising edge only; new alarm wins over a clear
  wire clrEdge = clrIn && !clrPrev_q;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      clrPrev_q <= 1'b0;
      alarm_q <= 1'b0;
    end else begin
      clrPrev_q <= clrIn;
      if (alarmEvent) begin
        alarm_q <= 1'b1;
      end else if (clrEdge) begin
        alarm_q <= 1'b0;
      end
    end
  end

  // toggle shaft output; 30 pulses per rev = 60 edges of ticks
  wire [POS_W-1:0] halfPulse = POS_W'(1);
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tickCnt_q <= '0;
      pulse_q <= 1'b0;
    end else if (shaftTick) begin
      if (tickCnt_q == halfPulse - POS_W'(1)) begin
        tickCnt_q <= '0;
        pulse_q <= !pulse_q;
      end else begin
        tickCnt_q <= tickCnt_q + POS_W'(1);
      end
    end
  end

  wire fwdCmd = dirIn ^ ctrl_q[`CTRL_DIRINV_BIT];
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fwd_q <= 1'b0;
    end else begin
      fwd_q <= fwdCmd;
    end
  end

  // torque clamp flag; limit from register
  wire capped = (torqueDemand > tLim_q) && (state_q != motor_io_pkg::MS_IDLE);
  // active unless alarm; forward while turning
  wire [3:0] funcVal = {fwd_q && (speed_q != '0), capped, !alarm_q, pulse_q};

  // output mapping and polarity, none on shaft pulse
  logic [3:0] outTerm_q;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_out
      wire [1:0] fsel = outMap_q[g*2 +: 2];
      wire polOn = outPol_q[g] && (fsel != motor_io_pkg::FO_SHAFT_PULSE);
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          outTerm_q[g] <= 1'b0;
        end else begin
          outTerm_q[g] <= funcVal[fsel] ^ polOn;
        end
      end
    end
  endgenerate
  assign digitalOutputTerminals = outTerm_q;

  // data entry from the select pair
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dataEntry <= 2'h0;
      speedRef <= 16'h0000;
      torqueRef <= 16'h0000;
      motorEnable <= 1'b0;
      motorForward <= 1'b0;
      speedLevel <= '0;
    end else begin
      dataEntry <= {selHigh, selLow};
      speedRef <= ctrl_q[`CTRL_PWMSEL_BIT] ? pwmSpeedRef : analogSpeedRef;
      torqueRef <= ctrl_q[`CTRL_PWMSEL_BIT] ? pwmTorqueRef : analogTorqueRef;
      motorEnable <= state_q != motor_io_pkg::MS_IDLE;
      motorForward <= fwd_q;
      speedLevel <= speed_q;
    end
  end

  // AXI4-Lite write: take address and data in either order
  logic awHeld_q, wHeld_q;
  logic [7:0] wAddr_q;
  logic [31:0] wData_q;
  assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
  wire doWrite = awHeld_q && wHeld_q;
  wire wHit = wAddr_q inside {`REG_CTRL_OFF, `REG_INPOL_OFF,
    `REG_OUTPOL_OFF, `REG_INMAP_OFF, `REG_OUTMAP_OFF, `REG_TLIM_OFF,
    `REG_FEED_OFF};
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      wAddr_q <= 8'h00;
      wData_q <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        wAddr_q <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wHit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register writes; byte strobes are ignored, whole words only
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_q <= 3'h0;
      inPol_q <= `INPOL_RESET;
      outPol_q <= `OUTPOL_RESET;
      inMap_q <= `INMAP_RESET;
      outMap_q <= `OUTMAP_RESET;
      tLim_q <= `TLIM_RESET;
      accelStep_q <= RAMP_W'(1);
      decelStep_q <= RAMP_W'(1);
    end else if (doWrite) begin
      unique case (wAddr_q)
        `REG_CTRL_OFF: ctrl_q <= wData_q[2:0];
        `REG_INPOL_OFF: inPol_q <= wData_q[5:0];
        `REG_OUTPOL_OFF: outPol_q <= wData_q[3:0];
        `REG_INMAP_OFF: inMap_q <= wData_q[17:0];
        `REG_OUTMAP_OFF: outMap_q <= wData_q[7:0];
        `REG_TLIM_OFF: tLim_q <= wData_q[15:0];
        `REG_FEED_OFF: begin
          accelStep_q <= wData_q[RAMP_W-1:0];
          decelStep_q <= wData_q[16 +: RAMP_W];
        end
        default: ;
      endcase
    end
  end

  // AXI4-Lite read, one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;
  logic [31:0] rdMux;
  logic rdHit;
  always_comb begin
    rdHit = 1'b1;
    rdMux = 32'h00000000;
    unique case (s_axi_araddr[7:0])
      `REG_CTRL_OFF: rdMux[2:0] = {alarm_q, ctrl_q[1:0]};
      `REG_INPOL_OFF: rdMux[5:0] = inPol_q;
      `REG_OUTPOL_OFF: rdMux[3:0] = outPol_q;
      `REG_INMAP_OFF: rdMux[17:0] = inMap_q;
      `REG_OUTMAP_OFF: rdMux[7:0] = outMap_q;
      `REG_TLIM_OFF: rdMux[15:0] = tLim_q;
      `REG_STATUS_OFF: rdMux[15:0] = {funcVal, dataEntry, inActive,
                                       2'(state_q), 2'h0};
      `REG_FEED_OFF: rdMux = {16'(decelStep_q), 16'(accelStep_q)};
      default: rdHit = 1'b0;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdMux;
      s_axi_rresp <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // permit loss means idle next cycle
  permit_stop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !runPermit |=> state_q == motor_io_pkg::MS_IDLE && speed_q == '0)
    else $error("motor not stopped at permit loss");
  start_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(motorEnable) |-> $past(runReq, 2) && $past(runPermit, 2))
    else $error("motor started without both inputs");
  ramp_down_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == motor_io_pkg::MS_RUN && !runReq && runPermit && !alarm_q
    |=> state_q == motor_io_pkg::MS_RAMP_DOWN)
    else $error("no decel ramp");
  clear_edge_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(alarm_q) |-> $past(clrIn) && !$past(clrPrev_q))
    else $error("alarm cleared without edge");
  fault_out_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    alarmEvent |=> funcVal[1] == 1'b0)
    else $error("fault-ok active during alarm");
  entry_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    1'b1 |=> dataEntry == $past({selHigh, selLow}))
    else $error("wrong data entry");
  dir_inv_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    1'b1 |=> fwd_q == ($past(dirIn) ^ $past(ctrl_q[`CTRL_DIRINV_BIT])))
    else $error("direction mapping wrong");
  // clamp reaches its default terminal, not just the internal flag
  torque_cap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    outMap_q[5:4] == 2'h2 && !outPol_q[2] && torqueDemand > tLim_q &&
    state_q != motor_io_pkg::MS_IDLE |=> digitalOutputTerminals[2])
    else $error("torque clamp not shown on terminal");
  // pins reach decode two cycles late
  pin_sync_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ##2 1'b1 |-> pinSync == $past(digitalInputTerminals, 2))
    else $error("input sync depth wrong");

  start_c: cover property (@(posedge clk_sys) $rose(motorEnable));
  brake_c: cover property (@(posedge clk_sys)
    $fell(runPermit) && speed_q != '0);
  clear_c: cover property (@(posedge clk_sys) $fell(alarm_q));
  rev_c: cover property (@(posedge clk_sys) $fell(motorForward));
endmodule

// >>> motor_io_params.svh
`ifndef MOTOR_IO_PARAMS_SVH
`define MOTOR_IO_PARAMS_SVH

// register byte offsets
`define REG_CTRL_OFF 8'h00
`define REG_INPOL_OFF 8'h04
`define REG_OUTPOL_OFF 8'h08
`define REG_INMAP_OFF 8'h0C
`define REG_OUTMAP_OFF 8'h10
`define REG_TLIM_OFF 8'h14
`define REG_STATUS_OFF 8'h18
`define REG_FEED_OFF 8'h1C

// control register fields
`define CTRL_DIRINV_BIT 0
`define CTRL_PWMSEL_BIT 1
`define CTRL_ALARM_BIT 2

// reset values
`define TLIM_RESET 16'h00C8
`define INPOL_RESET 6'h00
`define OUTPOL_RESET 4'h0
`define INMAP_RESET 18'h2C688
`define OUTMAP_RESET 8'hE4
`define PULSES_PER_REV 30

// bus answer codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> motor_io_pkg.sv
package motor_io_pkg;
  // input functions carried by terminals
  typedef enum logic [2:0] {
    FN_RUN_REQ, FN_RUN_PERMIT, FN_DIRECTION, FN_SEL_LOW, FN_SEL_HIGH,
    FN_FAULT_CLEAR
  } in_func_t;
  // output functions carried by terminals
  typedef enum logic [1:0] {
    FO_SHAFT_PULSE, FO_FAULT_OK, FO_TORQUE_CAPPED, FO_ROTATION_SENSE
  } out_func_t;
  // motion states
  typedef enum logic [1:0] {
    MS_IDLE, MS_RAMP_UP, MS_RUN, MS_RAMP_DOWN
  } motion_t;
endpackage

// >>> pin_sync.sv
`timescale 1ns/100ps
// two-stage synchroniser for a group of asynchronous pins
module pin_sync #(
  parameter int WIDTH = 6
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pinAsync,
  output logic [WIDTH-1:0] pinSync
);
  logic [WIDTH-1:0] meta_q;

  // first stage is read only by the second; reset level is "high" (idle)
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_q <= '1;
      pinSync <= '1;
    end else begin
      meta_q <= pinAsync;
      pinSync <= meta_q;
    end
  end
endmodule

// >>> ctrl_device.sv
`timescale 1ns/100ps
// far-side controller: drives the input terminals, counts shaft pulses
module ctrl_device (
  input wire logic clk_sys,
  input wire logic clr,
  input wire logic [5:0] fnActive,
  input wire logic [5:0] invMask,
  input wire logic shaftPin,
  output logic [5:0] pins,
  output int pulseCount
);
  logic shaftPrev;
  always @(posedge clk_sys) begin
    pins <= ~fnActive ^ invMask;
    shaftPrev <= shaftPin;
    if (clr) begin
      pulseCount <= 0;
    end else if (shaftPin && !shaftPrev) begin
      pulseCount <= pulseCount + 1;
    end
  end
endmodule

// >>> motor_driver_io_control_tb.sv
`timescale 1ns/100ps
`include "motor_io_params.svh"
module motor_driver_io_control_tb;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} exp_t;
  logic clk_sys = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, tick = 0, alarm = 0, clr = 1;
  logic awready, wready, bvalid, arready, rvalid, en, fwd;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic [1:0] bresp, rresp, entry;
  logic [5:0] act = 0, inv = 0, pins;
  logic [3:0] outs;
  logic [15:0] aSpd = 0, pSpd = 0, aTrq = 0, pTrq = 0, trq = 0;
  logic [15:0] spd, sRef, tRef;
  int pulses, failures = 0, comparisons = 0, seed = 32'haacd, i;
  exp_t q[$];
  exp_t e;
  // clock
  initial forever #2.5 clk_sys = ~clk_sys;
  ctrl_device i_dev (.clk_sys(clk_sys), .clr(clr), .fnActive(act),
    .invMask(inv), .shaftPin(outs[0]), .pins(pins), .pulseCount(pulses));
  motor_driver_io_control i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .digitalInputTerminals(pins), .digitalOutputTerminals(outs),
    .analogSpeedRef(aSpd), .pwmSpeedRef(pSpd), .analogTorqueRef(aTrq),
    .pwmTorqueRef(pTrq), .torqueDemand(trq), .shaftTick(tick),
    .alarmEvent(alarm), .motorEnable(en), .motorForward(fwd),
    .speedLevel(spd), .dataEntry(entry), .speedRef(sRef), .torqueRef(tRef));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // write: address and data offered together, bready held until bvalid
  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic [1:0] r = `RESP_OKAY);
    logic aw, w, bv;
    int n;
    q.push_back('{32'h0, 32'h0, r});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      bv = bvalid;
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end while (!bv && ++n < 200);
    if (!bv) begin
      failures++;
      $display("[FAIL] %0t no write response", $time);
    end
    // release, then let an edge pass so no signal is set twice at once
    bready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] d,
                    input logic [31:0] m = 32'hFFFFFFFF,
                    input logic [1:0] r = `RESP_OKAY);
    logic ar, rv;
    int n;
    q.push_back('{d, m, r});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ar = 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      rv = rvalid;
      if (ar && arready) begin
        ar = 1'b0;
        arvalid <= 1'b0;
      end
    end while (!rv && ++n < 200);
    if (!rv) begin
      failures++;
      $display("[FAIL] %0t no read response", $time);
    end
    rready <= 1'b0;
    @(posedge clk_sys);
  endtask
  // partner edge, two sync edges, then up to three register stages;
  // a result launched at the sixth edge is seen at the seventh: wait seven
  task automatic settle;
    repeat (7) @(posedge clk_sys);
  endtask
  task automatic fault;
    alarm <= 1'b1;
    @(posedge clk_sys);
    alarm <= 1'b0;
    settle;
  endtask
  // answer monitor: oldest note is compared when a response lands
  always @(posedge clk_sys) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      e = q.pop_front();
      chk({30'h0, bvalid ? bresp : rresp}, {30'h0, e.r});
      if (rvalid) chk(rdata & e.m, e.d & e.m);
    end
  end
  // watchdog: whole sequence needs well under this
  initial begin
    repeat (30000) @(posedge clk_sys);
    failures++;
    $display("[FAIL] %0t sequence hung", $time);
    stop_test;
  end
  // main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    clr <= 1'b0;
    aSpd <= 16'($random(seed));
    pSpd <= 16'($random(seed));
    aTrq <= 16'($random(seed));
    pTrq <= 16'($random(seed));
    rd(`REG_TLIM_OFF, `TLIM_RESET);
    rd(`REG_INMAP_OFF, `INMAP_RESET);
    rd(`REG_OUTMAP_OFF, `OUTMAP_RESET);
    rd(`REG_INPOL_OFF, `INPOL_RESET);
    rd(`REG_OUTPOL_OFF, `OUTPOL_RESET);
    rd(32'h20, 32'h0, 32'hFFFFFFFF, `RESP_SLVERR);
    wr(32'h24, 32'h5, `RESP_SLVERR);
    wr(`REG_TLIM_OFF, 32'h64);
    rd(`REG_TLIM_OFF, 32'h64, 32'hFFFF);
    // demand above limit, but an idle motor produces no torque to clamp
    trq <= 16'h0065;
    settle;
    chk(outs[2], 1'b0);
    chk(outs[1], 1'b1);
    fault;
    chk(outs[1], 1'b0);
    rd(`REG_CTRL_OFF, 32'h4, 32'h4);
    act[5] <= 1'b1;
    settle;
    chk(outs[1], 1'b1);
    fault;
    chk(outs[1], 1'b0);
    act[5] <= 1'b0;
    settle;
    chk(outs[1], 1'b0);
    act[5] <= 1'b1;
    settle;
    chk(outs[1], 1'b1);
    chk({sRef, tRef}, {aSpd, aTrq});
    wr(`REG_CTRL_OFF, 32'h2);
    settle;
    chk({sRef, tRef}, {pSpd, pTrq});
    for (i = 0; i < 4; i++) begin
      act[4:3] <= i[1:0];
      settle;
      chk(entry, i[1:0]);
    end
    act[1] <= 1'b1;
    settle;
    chk(en, 1'b0);
    wr(`REG_FEED_OFF, 32'h00014000);
    act[0] <= 1'b1;
    act[2] <= 1'b1;
    settle;
    chk(en, 1'b1);
    chk({fwd, outs[3]}, 2'b11);
    repeat (8) @(posedge clk_sys);
    chk(spd, 16'hFFFF);
    chk(outs[2], 1'b1);
    trq <= 16'h0063;
    settle;
    chk(outs[2], 1'b0);
    wr(`REG_CTRL_OFF, 32'h3);
    settle;
    chk(fwd, 1'b0);
    wr(`REG_CTRL_OFF, 32'h2);
    act[2] <= 1'b0;
    settle;
    chk({fwd, outs[3]}, 2'b00);
    for (i = 0; i < 60; i++) begin
      tick <= 1'b1;
      @(posedge clk_sys);
      tick <= 1'b0;
      @(posedge clk_sys);
    end
    settle;
    chk(pulses, 30);
    wr(`REG_OUTPOL_OFF, 32'hF);
    settle;
    chk(outs[1:0], 2'b00);
    wr(`REG_OUTPOL_OFF, 32'h0);
    act[0] <= 1'b0;
    settle;
    rd(`REG_STATUS_OFF, {motor_io_pkg::MS_RAMP_DOWN, 2'b00}, 32'hC);
    chk({en, spd != 16'h0, spd != 16'hFFFF}, 3'b111);
    act[1] <= 1'b0;
    settle;
    chk({en, spd}, 17'h0);
    wr(`REG_INPOL_OFF, 32'h3);
    inv <= 6'h03;
    act[1:0] <= 2'b11;
    settle;
    chk(en, 1'b1);
    act[1] <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(en, 1'b1);
    settle;
    chk(en, 1'b0);
    stop_test;
  end
endmodule
